/* design/adc_pins_pkg.sv */
/*
 Constants, offsets, reset values and carrier types for the shared serial pins block.
 Assumes a single 50 MHz clock domain and a plain strobe-based register port.
*/
// Operation
// - Modes 0-2: pins carry result bits 12-16
// - Serial master: drive frame sync output
// - Polarity low: frame sync high during data
// - Polarity high: frame sync low during data
// - Slave unfinished read at conversion: pulse error
// - Software select: settings from serial register
// - Hardware select: settings from config pins
// - Config bits shifted MSB first, config clock
// - Edge invert picks active clock edge
package adc_pins_pkg;
    localparam int        RES_W      = 18;
    localparam int        PIN_LO     = 12;
    localparam int        N_SHARED   = 5;
    localparam int        CFG_W      = 12;
    localparam logic [1:0] MODE_SERIAL = 2'h3;
    localparam logic [1:0] RST_MODE    = 2'h0;
    localparam int        ADDR_W     = 8;
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CLEAR  = 8'h08;
    localparam logic [7:0] OFS_ENABLE = 8'h0C;
    localparam logic [7:0] OFS_SOFT   = 8'h10;
    localparam logic [7:0] OFS_ACTIVE = 8'h14;
    localparam int        N_EV       = 3;
    localparam int        EV_RDERR   = 0;
    localparam int        EV_CFG     = 1;
    localparam int        EV_FRAME   = 2;
    localparam logic [2:0] RST_EV     = 3'h0;
    localparam int        PIN_SYNC   = 0;
    localparam int        PIN_ERR    = 1;
    localparam int        PIN_SRC    = 2;
    localparam int        SI_SRC     = 0;
    localparam int        SI_CIN     = 1;
    localparam int        SI_CCLK    = 2;
    localparam int        SI_RCLK    = 3;
    localparam int        SI_CPS     = 4;
    localparam int        SI_INV     = 5;
    localparam int        SI_POL     = 6;
    localparam int        SI_CLKSRC  = 7;
    localparam int        SI_HW      = 8;
    localparam int        MCLK_MHZ   = 50;
    localparam int        SCLK_HALF_NS  = 80;
    localparam int        SCLK_HALF_CYC = (SCLK_HALF_NS * MCLK_MHZ) / 1000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SHIFT = 2'b10
    } shift_st_t;
endpackage

/* design/adc_serial_sync_config_pins.sv */
/*
 Shared result/serial pins: parallel bits 12-16, frame sync, read error flag,
 configuration source select and serial configuration port.
 Assumes the conversion core gives result_data, conv_done and read_start on mclk.
*/
`timescale 1ns/10ps
`default_nettype none
module adc_serial_sync_config_pins #(
    parameter int CFG_BITS = adc_pins_pkg::CFG_W
) (
    input  wire logic                              mclk,
    input  wire logic                              arst_n,
    input  wire adc_pins_pkg::reg_req_t            bus_req,
    output logic [31:0]                            rdata,
    output logic                                   irq,
    input  wire logic [adc_pins_pkg::RES_W-1:0]    result_data,
    input  wire logic                              conv_done,
    input  wire logic                              read_start,
    input  wire logic [adc_pins_pkg::N_SHARED-1:0] shared_pin_i,
    output logic [adc_pins_pkg::N_SHARED-1:0]      shared_pin_o,
    output logic [adc_pins_pkg::N_SHARED-1:0]      shared_pin_oe,
    input  wire logic                              result_clk_i,
    output logic                                   result_clk_o,
    output logic                                   result_clk_oe,
    output logic                                   serial_result_out,
    input  wire logic                              config_port_select_n,
    input  wire logic                              clock_edge_invert,
    input  wire logic                              frame_sync_polarity,
    input  wire logic                              clock_source_select,
    input  wire logic [CFG_BITS-1:0]               hw_config,
    output logic [CFG_BITS-1:0]                    cfg_active
);
    import adc_pins_pkg::*;

    localparam int NS     = SI_HW + CFG_BITS;
    localparam int CNT_W  = $clog2(RES_W + 1);
    localparam int CCNT_W = $clog2(CFG_BITS + 1);
    localparam int DIV_W  = $clog2(SCLK_HALF_CYC + 1);

    function automatic logic act_edge(input logic prev, input logic cur, input logic inv);
        act_edge = inv ? (prev & ~cur) : (~prev & cur);
    endfunction

    // Three-stage sampling; a level is accepted once stages two and three agree
    logic [NS-1:0] async_in;
    logic [NS-1:0] s1_r;
    logic [NS-1:0] s2_r;
    logic [NS-1:0] s3_r;
    logic [NS-1:0] flt_r;
    logic [NS-1:0] flt_nxt;
    logic [NS-1:0] prev_r;

    assign async_in = {hw_config, clock_source_select, frame_sync_polarity,
                       clock_edge_invert, config_port_select_n, result_clk_i,
                       shared_pin_i[N_SHARED-1:PIN_SRC]};

    always_comb begin
        flt_nxt = ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & flt_r);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r   <= '0;
            s2_r   <= '0;
            s3_r   <= '0;
            flt_r  <= '0;
            prev_r <= '0;
        end else begin
            s1_r   <= async_in;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            flt_r  <= flt_nxt;
            prev_r <= flt_r;
        end
    end

    logic [1:0]          mode_r;
    logic                serial;
    logic                master;
    logic                slave;
    logic                sw;
    logic                inv;
    logic                pol;
    logic                rclk_act;
    logic                cclk_act;
    logic [CFG_BITS-1:0] hw_f;

    assign serial   = (mode_r == MODE_SERIAL);
    assign master   = serial & ~flt_r[SI_CLKSRC];
    assign slave    = serial & flt_r[SI_CLKSRC];
    assign sw       = serial & ~flt_r[SI_SRC];
    assign inv      = flt_r[SI_INV];
    assign pol      = flt_r[SI_POL];
    assign hw_f     = flt_r[SI_HW +: CFG_BITS];
    assign rclk_act = act_edge(prev_r[SI_RCLK], flt_r[SI_RCLK], inv);
    assign cclk_act = act_edge(prev_r[SI_CCLK], flt_r[SI_CCLK], inv);

    // Result shifting: master makes its own clock, slave follows the sampled one
    shift_st_t        st_r;
    shift_st_t        st_nxt;
    logic [RES_W-1:0] sh_r;
    logic [RES_W-1:0] sh_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [DIV_W-1:0] div_r;
    logic [DIV_W-1:0] div_nxt;
    logic             sck_r;
    logic             sck_nxt;
    logic             fsa_r;
    logic             fsa_nxt;
    logic             sdo_nxt;
    logic             ld_r;
    logic             ld_nxt;
    logic             err_nxt;
    logic             ev_frame;

    always_comb begin
        st_nxt   = st_r;
        sh_nxt   = sh_r;
        cnt_nxt  = cnt_r;
        div_nxt  = div_r;
        sck_nxt  = sck_r;
        fsa_nxt  = fsa_r;
        sdo_nxt  = serial_result_out;
        ld_nxt   = ld_r;
        err_nxt  = 1'b0;
        ev_frame = 1'b0;
        if (master) begin
            unique case (st_r)
                ST_IDLE: begin
                    sck_nxt = inv;
                    fsa_nxt = 1'b0;
                    div_nxt = '0;
                    if (read_start) begin
                        st_nxt  = ST_SHIFT;
                        fsa_nxt = 1'b1;
                        sdo_nxt = result_data[RES_W-1];
                        sh_nxt  = {result_data[RES_W-2:0], 1'b0};
                        cnt_nxt = '0;
                    end
                end
                ST_SHIFT: begin
                    div_nxt = DIV_W'(div_r + 1'b1);
                    if (div_r == DIV_W'(SCLK_HALF_CYC - 1)) begin
                        div_nxt = '0;
                        sck_nxt = ~sck_r;
                        if (sck_r == inv) begin
                            cnt_nxt = CNT_W'(cnt_r + 1'b1);
                        end else if (cnt_r == CNT_W'(RES_W)) begin
                            st_nxt   = ST_IDLE;
                            fsa_nxt  = 1'b0;
                            ev_frame = 1'b1;
                        end else begin
                            // Data moves on the idle-going edge so it is stable at the active edge
                            sdo_nxt = sh_r[RES_W-1];
                            sh_nxt  = {sh_r[RES_W-2:0], 1'b0};
                        end
                    end
                end
                default: st_nxt = ST_IDLE;
            endcase
        end else begin
            st_nxt  = ST_IDLE;
            fsa_nxt = 1'b0;
            sck_nxt = inv;
            div_nxt = '0;
            if (slave) begin
                if (conv_done) begin
                    // A new result overrides a read in progress; the old word is lost
                    if (cnt_r != '0 && cnt_r != CNT_W'(RES_W)) begin
                        err_nxt = 1'b1;
                    end
                    ld_nxt  = 1'b1;
                    cnt_nxt = '0;
                    sdo_nxt = result_data[RES_W-1];
                    sh_nxt  = {result_data[RES_W-2:0], 1'b0};
                end else if (ld_r && rclk_act) begin
                    cnt_nxt = CNT_W'(cnt_r + 1'b1);
                    sdo_nxt = sh_r[RES_W-1];
                    sh_nxt  = {sh_r[RES_W-2:0], 1'b0};
                    if (cnt_r == CNT_W'(RES_W - 1)) begin
                        ld_nxt = 1'b0;
                    end
                end
            end
        end
    end

    // Shared pin drive, registered from the next-state values
    logic [N_SHARED-1:0] pin_o_nxt;
    logic [N_SHARED-1:0] pin_oe_nxt;

    always_comb begin
        pin_o_nxt  = '0;
        pin_oe_nxt = '0;
        if (!serial) begin
            pin_o_nxt  = result_data[PIN_LO +: N_SHARED];
            pin_oe_nxt = '1;
        end else begin
            pin_o_nxt[PIN_SYNC]  = master & (fsa_nxt ^ pol);
            pin_oe_nxt[PIN_SYNC] = master;
            pin_o_nxt[PIN_ERR]   = err_nxt;
            pin_oe_nxt[PIN_ERR]  = slave;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_r              <= ST_IDLE;
            sh_r              <= '0;
            cnt_r             <= '0;
            div_r             <= '0;
            sck_r             <= 1'b0;
            fsa_r             <= 1'b0;
            serial_result_out <= 1'b0;
            ld_r              <= 1'b0;
            shared_pin_o      <= '0;
            shared_pin_oe     <= '0;
            result_clk_o      <= 1'b0;
            result_clk_oe     <= 1'b0;
        end else begin
            st_r              <= st_nxt;
            sh_r              <= sh_nxt;
            cnt_r             <= cnt_nxt;
            div_r             <= div_nxt;
            sck_r             <= sck_nxt;
            fsa_r             <= fsa_nxt;
            serial_result_out <= sdo_nxt;
            ld_r              <= ld_nxt;
            shared_pin_o      <= pin_o_nxt;
            shared_pin_oe     <= pin_oe_nxt;
            result_clk_o      <= sck_nxt;
            result_clk_oe     <= master;
        end
    end

    // Serial configuration port; a word is kept only if a full word arrived
    logic [CFG_BITS-1:0] csh_r;
    logic [CFG_BITS-1:0] csh_nxt;
    logic [CCNT_W-1:0]   ccnt_r;
    logic [CCNT_W-1:0]   ccnt_nxt;
    logic [CFG_BITS-1:0] soft_r;
    logic [CFG_BITS-1:0] soft_nxt;
    logic [CFG_BITS-1:0] act_nxt;
    logic                ev_cfg;
    logic                cps_act;
    logic                cps_end;

    assign cps_act = sw & ~flt_r[SI_CPS];
    assign cps_end = sw & ~prev_r[SI_CPS] & flt_r[SI_CPS];

    always_comb begin
        csh_nxt  = csh_r;
        ccnt_nxt = ccnt_r;
        soft_nxt = soft_r;
        ev_cfg   = 1'b0;
        if (cps_act && cclk_act) begin
            csh_nxt = {csh_r[CFG_BITS-2:0], flt_r[SI_CIN]};
            if (ccnt_r != CCNT_W'(CFG_BITS)) begin
                ccnt_nxt = CCNT_W'(ccnt_r + 1'b1);
            end
        end else if (cps_end) begin
            ccnt_nxt = '0;
            if (ccnt_r == CCNT_W'(CFG_BITS)) begin
                soft_nxt = csh_r;
                ev_cfg   = 1'b1;
            end
        end
        act_nxt = sw ? soft_r : hw_f;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            csh_r      <= '0;
            ccnt_r     <= '0;
            soft_r     <= '0;
            cfg_active <= '0;
        end else begin
            csh_r      <= csh_nxt;
            ccnt_r     <= ccnt_nxt;
            soft_r     <= soft_nxt;
            cfg_active <= act_nxt;
        end
    end

    // Register port and interrupt; a set beats a clear in the same cycle
    logic [1:0]      mode_nxt;
    logic [N_EV-1:0] stat_r;
    logic [N_EV-1:0] stat_nxt;
    logic [N_EV-1:0] en_r;
    logic [N_EV-1:0] en_nxt;
    logic [N_EV-1:0] ev;
    logic [N_EV-1:0] clr;
    logic [31:0]     rdata_nxt;

    always_comb begin
        ev           = '0;
        ev[EV_RDERR] = err_nxt;
        ev[EV_CFG]   = ev_cfg;
        ev[EV_FRAME] = ev_frame;
        clr          = '0;
        mode_nxt     = mode_r;
        en_nxt       = en_r;
        rdata_nxt    = '0;
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                OFS_CTRL:   mode_nxt = bus_req.wdata[1:0];
                OFS_CLEAR:  clr = bus_req.wdata[N_EV-1:0];
                OFS_ENABLE: en_nxt = bus_req.wdata[N_EV-1:0];
                default:    ;
            endcase
        end
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                OFS_CTRL:   rdata_nxt[1:0] = mode_r;
                OFS_STATUS: rdata_nxt[N_EV-1:0] = stat_r;
                OFS_ENABLE: rdata_nxt[N_EV-1:0] = en_r;
                OFS_SOFT:   rdata_nxt[CFG_BITS-1:0] = soft_r;
                OFS_ACTIVE: rdata_nxt[CFG_BITS-1:0] = cfg_active;
                default:    ;
            endcase
        end
        stat_nxt = (stat_r & ~clr) | ev;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mode_r <= RST_MODE;
            stat_r <= RST_EV;
            en_r   <= RST_EV;
            rdata  <= '0;
            irq    <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            stat_r <= stat_nxt;
            en_r   <= en_nxt;
            rdata  <= rdata_nxt;
            irq    <= |(stat_nxt & en_nxt);
        end
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    logic [N_SHARED-1:0] par_bits;
    logic [CFG_BITS-1:0] csh_shift;
    assign par_bits  = result_data[PIN_LO +: N_SHARED];
    assign csh_shift = {csh_r[CFG_BITS-2:0], flt_r[SI_CIN]};

    sequence m_start;
        st_r == ST_IDLE && master && read_start;
    endsequence

    sequence frame_ends;
        ##[1:400] (st_r == ST_IDLE);
    endsequence

    par_pins_a: assert property (
        !serial |=> (shared_pin_o == $past(par_bits)) && (&shared_pin_oe))
        else $error("parallel bits not on shared pins");
    fs_frame_a: assert property (
        m_start |-> frame_ends)
        else $error("master frame did not end");
    fs_high_a: assert property (
        (m_start and !pol) |=> (shared_pin_o[PIN_SYNC] && shared_pin_oe[PIN_SYNC]) [*8])
        else $error("frame sync not held high");
    fs_low_a: assert property (
        (m_start and pol) |=> (!shared_pin_o[PIN_SYNC] && shared_pin_oe[PIN_SYNC]) [*8])
        else $error("frame sync not held low");
    rd_err_a: assert property (
        slave && conv_done && cnt_r != '0 && cnt_r != CNT_W'(RES_W)
        |=> shared_pin_o[PIN_ERR] && cnt_r == '0)
        else $error("read error not flagged");
    sw_cfg_a: assert property (
        sw |=> cfg_active == $past(soft_r))
        else $error("software settings not used");
    hw_cfg_a: assert property (
        !sw |=> cfg_active == $past(hw_f))
        else $error("pin settings not used");
    cfg_shift_a: assert property (
        cps_act && cclk_act |=> csh_r == $past(csh_shift))
        else $error("config bit not shifted in");
    edge_sel_a: assert property (
        slave && ld_r && !conv_done && (inv ? $fell(flt_r[SI_RCLK]) : $rose(flt_r[SI_RCLK]))
        |=> cnt_r == $past(cnt_r) + 1'b1)
        else $error("wrong result clock edge used");
endmodule
`default_nettype wire

/* test/host_link_model.sv */
/*
 Host-side model of the serial link: slave result clock and config port.
 Assumes the bench calls its tasks and resolves the shared pins itself.
*/
`timescale 1ns/10ps
`default_nettype none
module host_link_model (
    input  wire logic inv,
    input  wire logic sdo,
    output logic      rclk,
    output logic      cclk,
    output logic      cdin,
    output logic      csel_n
);
    logic ract;
    logic cact;
    // Clocks rest at the idle level between frames
    assign rclk = inv ^ ract;
    assign cclk = inv ^ cact;
    initial begin
        ract = 1'b0;
        cact = 1'b0;
        cdin = 1'b0;
        csel_n = 1'b1;
    end
    // Sample just before each active edge, 160 ns link period
    task automatic slave_read(input int n, output logic [17:0] got);
        got = '0;
        for (int k = 0; k < n; k++) begin
            got = {got[16:0], sdo};
            ract = 1'b1;
            #80;
            ract = 1'b0;
            #80;
        end
    endtask
    task automatic send_cfg(input logic [15:0] w, input int n);
        csel_n = 1'b0;
        #160;
        for (int i = n - 1; i >= 0; i--) begin
            cdin = w[i];
            #80;
            cact = 1'b1;
            #80;
            cact = 1'b0;
        end
        #80;
        // Released line shows the inverse so a stale bit cannot pass
        cdin = ~cdin;
        csel_n = 1'b1;
        #160;
    endtask
endmodule
`default_nettype wire

/* test/adc_serial_sync_config_pins_tb.sv */
/*
 Self-checking bench for the shared serial pins block.
 Assumes the host model file and the design package are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module adc_serial_sync_config_pins_tb;
    import adc_pins_pkg::*;
    logic                mclk = 1'b0;
    logic                arst_n;
    reg_req_t            bus_req;
    logic [31:0]         rdata;
    logic                irq, conv_done, read_start, rclk_o, rclk_oe, sdo;
    logic [RES_W-1:0]    result_data;
    logic [N_SHARED-1:0] pin_i, pin_o, pin_oe, host_pins;
    logic                hw_sel, rclk, cclk, cdin, csel_n, inv, pol, csrc;
    logic [CFG_W-1:0]    hw_config, cfg_active;
    logic [31:0]         seed;
    logic [31:0]         exp_q[$];
    logic                rd_seen = 1'b0;
    logic [17:0]         a, b, got;
    int                  ne;
    int                  n_mismatch = 0;
    int                  samples_checked = 0;

    always #10 mclk = ~mclk;
    assign host_pins = {cclk, cdin, hw_sel, seed[1:0]};
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & host_pins);

    adc_serial_sync_config_pins #(.CFG_BITS(CFG_W)) dut_u (
        .mclk(mclk), .arst_n(arst_n), .bus_req(bus_req), .rdata(rdata),
        .irq(irq), .result_data(result_data), .conv_done(conv_done),
        .read_start(read_start), .shared_pin_i(pin_i), .shared_pin_o(pin_o),
        .shared_pin_oe(pin_oe), .result_clk_i(rclk_oe ? rclk_o : rclk),
        .result_clk_o(rclk_o), .result_clk_oe(rclk_oe), .serial_result_out(sdo),
        .config_port_select_n(csel_n), .clock_edge_invert(inv),
        .frame_sync_polarity(pol), .clock_source_select(csrc),
        .hw_config(hw_config), .cfg_active(cfg_active));
    host_link_model host_u (.inv(inv), .sdo(sdo), .rclk(rclk), .cclk(cclk),
        .cdin(cdin), .csel_n(csel_n));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (e !== g) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d);
        @(posedge mclk);
        bus_req <= {ad, d, 1'b1, 1'b0};
        @(posedge mclk);
        bus_req <= '0;
    endtask
    task automatic rd_reg(input logic [7:0] ad, input logic [31:0] e);
        @(posedge mclk);
        exp_q.push_back(e);
        bus_req <= {ad, 32'h0, 1'b0, 1'b1};
        @(posedge mclk);
        bus_req <= '0;
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge mclk) begin
        if (rd_seen) chk("rdata", exp_q.pop_front(), rdata);
        rd_seen <= bus_req.rd;
    end
    task automatic m_read(input logic p, input logic v);
        logic [17:0] ex;
        logic        bad, prev;
        int          e, t;
        @(posedge mclk);
        pol <= p;
        inv <= v;
        cyc(6);
        @(posedge mclk);
        seed = lfsr(seed);
        ex = seed[17:0];
        result_data <= ex;
        read_start <= 1'b1;
        @(posedge mclk);
        read_start <= 1'b0;
        @(posedge mclk);
        bad = 1'b0;
        prev = v;
        e = 0;
        t = 0;
        got = '0;
        while (e < 18 && t < 400) begin
            @(negedge mclk);
            t++;
            if (pin_o[PIN_SYNC] !== ~p) bad = 1'b1;
            if (rclk_o !== prev && rclk_o === ~v) begin
                got = {got[16:0], sdo};
                e++;
            end
            prev = rclk_o;
        end
        chk("master word", ex, got);
        chk("sync in frame", 0, bad);
        cyc(12);
        chk("sync after frame", p, pin_o[PIN_SYNC]);
        chk("master clock oe", 1, rclk_oe);
        chk("sync oe", 1, pin_oe[PIN_SYNC]);
    endtask
    task automatic conv(output logic [17:0] ex, output int n);
        @(posedge mclk);
        seed = lfsr(seed);
        ex = seed[17:0];
        result_data <= ex;
        conv_done <= 1'b1;
        @(posedge mclk);
        conv_done <= 1'b0;
        n = 0;
        repeat (6) begin
            @(negedge mclk);
            if (pin_o[PIN_ERR] === 1'b1) n++;
        end
    endtask

    // Whole run is some 32 us; over twelve times that cuts a hang short
    initial begin
        #400000;
        n_mismatch++;
        give_verdict;
    end
    initial begin
        seed = 32'h6AB6;
        bus_req = '0;
        arst_n = 1'b0;
        result_data = '0;
        conv_done = 1'b0;
        read_start = 1'b0;
        hw_sel = 1'b0;
        inv = 1'b0;
        pol = 1'b0;
        csrc = 1'b0;
        hw_config = 12'hA5C;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        cyc(4);
        rd_reg(OFS_CTRL, 0);
        rd_reg(8'h3C, 0);
        wr_reg(OFS_STATUS, 7);
        wr_reg(OFS_ENABLE, 7);
        rd_reg(OFS_ENABLE, 7);
        rd_reg(OFS_STATUS, 0);
        for (int m = 0; m < 3; m++) begin
            wr_reg(OFS_CTRL, m);
            @(posedge mclk);
            seed = lfsr(seed);
            result_data <= seed[17:0];
            cyc(3);
            chk("parallel pins", result_data[16:12], pin_o);
            chk("parallel oe", 5'h1F, pin_oe);
        end
        wr_reg(OFS_CTRL, MODE_SERIAL);
        cyc(6);
        m_read(0, 1);
        m_read(1, 1);
        m_read(1, 0);
        m_read(0, 0);
        rd_reg(OFS_STATUS, 4);
        cyc(2);
        chk("irq frame", 1, irq);
        wr_reg(OFS_CLEAR, 7);
        wr_reg(OFS_ENABLE, 2);
        cyc(3);
        chk("irq cleared", 0, irq);
        @(posedge mclk);
        csrc <= 1'b1;
        cyc(6);
        chk("slave clock oe", 0, rclk_oe);
        chk("slave sync oe", 0, pin_oe[PIN_SYNC]);
        conv(a, ne);
        host_u.slave_read(18, got);
        chk("slave word", a, got);
        @(posedge mclk);
        inv <= 1'b1;
        cyc(6);
        conv(a, ne);
        chk("no error pulse", 0, ne);
        host_u.slave_read(5, got);
        conv(b, ne);
        chk("error pulse", 1, ne);
        chk("error oe", 1, pin_oe[PIN_ERR]);
        chk("irq masked", 0, irq);
        rd_reg(OFS_STATUS, 1);
        host_u.slave_read(18, got);
        chk("word after error", b, got);
        wr_reg(OFS_ENABLE, 3);
        cyc(3);
        chk("irq error", 1, irq);
        wr_reg(OFS_CLEAR, 1);
        cyc(3);
        chk("irq error clr", 0, irq);
        @(posedge mclk);
        csrc <= 1'b0;
        inv <= 1'b0;
        cyc(6);
        host_u.send_cfg(16'h0C35, 12);
        cyc(8);
        rd_reg(OFS_SOFT, 32'hC35);
        chk("soft active", 12'hC35, cfg_active);
        @(posedge mclk);
        inv <= 1'b1;
        cyc(6);
        host_u.send_cfg(16'h05A3, 12);
        cyc(8);
        rd_reg(OFS_SOFT, 32'h5A3);
        host_u.send_cfg(16'h00FF, 8);
        cyc(8);
        rd_reg(OFS_SOFT, 32'h5A3);
        chk("irq config", 1, irq);
        @(posedge mclk);
        hw_sel <= 1'b1;
        cyc(8);
        chk("hw active", hw_config, cfg_active);
        host_u.send_cfg(16'h0123, 12);
        cyc(8);
        rd_reg(OFS_SOFT, 32'h5A3);
        chk("hw still", hw_config, cfg_active);
        cyc(2);
        give_verdict;
    end
endmodule
`default_nettype wire
